// *** inc/bls_pkg.sv ***
package bls_pkg;

    // ------------------------------------------------------------
    // Bus cycle states, Gray coded along the normal path
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BLS_IDLE = 2'h0,
        BLS_ADDR = 2'h1,
        BLS_DATA = 2'h3,
        BLS_REL  = 2'h2
    } bls_state_t;

    // ------------------------------------------------------------
    // Transfer-size codes driven on xfer_size_hi/lo
    // ------------------------------------------------------------
    localparam logic [1:0] BLS_SIZE_BYTE  = 2'h1;
    localparam logic [1:0] BLS_SIZE_WORD  = 2'h2;
    localparam logic [1:0] BLS_SIZE_THREE = 2'h3;
    localparam logic [1:0] BLS_SIZE_LONG  = 2'h0;

    // ------------------------------------------------------------
    // Port width answers as {ack_hi_n, ack_lo_n}, active low
    // ------------------------------------------------------------
    localparam logic [1:0] BLS_ACK_32   = 2'h0;
    localparam logic [1:0] BLS_ACK_16   = 2'h1;
    localparam logic [1:0] BLS_ACK_8    = 2'h2;
    localparam logic [1:0] BLS_ACK_NONE = 2'h3;

    // ------------------------------------------------------------
    // Byte counts and alignment
    // ------------------------------------------------------------
    localparam logic [2:0] BLS_LONG_BYTES = 3'h4;
    localparam logic [2:0] BLS_WORD_BYTES = 3'h2;
    localparam logic [2:0] BLS_ONE_BYTE   = 3'h1;
    localparam logic [1:0] BLS_LONG_ALIGN = 2'h0;

endpackage

// *** verilog/bls_lane_mux.sv ***
`timescale 1ns/10ps
`default_nettype none

module bls_lane_mux
    import bls_pkg::*;
(
    // Write side: remaining operand bytes, most significant first
    input  wire logic [31:0] i_wbytes,
    input  wire logic [1:0]  i_offset,
    output logic      [31:0] o_wlanes,
    // Read side: bus lanes and first valid lane
    input  wire logic [31:0] i_rbus,
    input  wire logic [1:0]  i_rlane,
    output logic      [31:0] o_rshift
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] opb(input logic [31:0] v,
                                       input logic [1:0]  k);
        opb = v[(8 * (3 - int'(k))) +: 8];
    endfunction

    // ------------------------------------------------------------
    // Write lanes
    // ------------------------------------------------------------
    // Bytes are replicated so that 8- and 16-bit ports on the upper
    // lanes see the same byte that a 32-bit port sees at its offset
    always_comb begin
        o_wlanes[31:24] = opb(i_wbytes, 2'h0);                 // RQ6
        o_wlanes[23:16] = i_offset[0] ? opb(i_wbytes, 2'h0)
                                      : opb(i_wbytes, 2'h1);   // RQ6
        case (i_offset)
            2'h0:    o_wlanes[15:8] = opb(i_wbytes, 2'h2);
            2'h1:    o_wlanes[15:8] = opb(i_wbytes, 2'h1);
            default: o_wlanes[15:8] = opb(i_wbytes, 2'h0);
        endcase
        o_wlanes[7:0] = opb(i_wbytes, 2'h3 - i_offset);
    end

    // ------------------------------------------------------------
    // Read lanes
    // ------------------------------------------------------------
    // First valid lane is moved to the top byte
    always_comb begin
        o_rshift = i_rbus << {i_rlane, 3'h0};
    end

endmodule

`default_nettype wire

// *** verilog/bls_bus_sizer.sv ***
// Behaviour
// [RQ1] Size lines carry bytes still to move
// [RQ2] Low address points at next MSB byte
// [RQ3] Port reports its width on acknowledges
// [RQ4] Narrow ports sit on upper lanes
// [RQ5] Any size, any alignment, split as needed
// [RQ6] Misaligned long word to word port: three cycles
// [RQ7] Wide ports get one strobe per lane
// [RQ8] Lanes decoded from size and address bits
// [RQ9] 32-bit upper lanes decode
// [RQ10] 32-bit lower lanes decode
// [RQ11] 16-bit lane decode from address bit zero
// [RQ12] 8-bit port may use either strobe
// [RQ13] Cachable reads return full port width
// [RQ14] Instruction fetches are long-word aligned
// [RQ15] Reads enable all lanes, writes decoded
// [RQ16] Mapped bank selects plus unmapped selects
// [RQ17] Mapped selects need bank and space match
// [RQ18] Selects combinational, active low, stateless
`timescale 1ns/10ps
`default_nettype none

module bls_bus_sizer
    import bls_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Operand request
    input  wire logic        i_req,
    input  wire logic [1:0]  i_req_size,
    input  wire logic [31:0] i_req_addr,
    input  wire logic        i_req_write,
    input  wire logic        i_req_instr,
    input  wire logic [31:0] i_req_wdata,
    output logic             o_req_ready,
    output logic             o_done,
    output logic      [31:0] o_rdata,
    // Processor bus
    output logic      [31:0] o_addr,
    output logic             o_xfer_size_hi,
    output logic             o_xfer_size_lo,
    output logic             o_read_write,
    output logic             o_address_valid_strobe_n,
    output logic             o_data_phase_strobe_n,
    output logic      [31:0] o_data_out,
    output logic             o_data_oe,
    input  wire logic [31:0] i_data_in,
    input  wire logic        i_port_width_ack_hi_n,
    input  wire logic        i_port_width_ack_lo_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bls_state_t  st;
        logic [31:0] addr;
        logic [2:0]  remain;
        logic [2:0]  total;
        logic [2:0]  dcnt;
        logic        write;
        logic [31:0] wbuf;
        logic [31:0] rbuf;
        logic [31:0] dout;
        logic [31:0] rdata;
        logic        done;
        logic [1:0]  ack_s1;
        logic [1:0]  ack_s2;
        logic [31:0] din_s1;
        logic [31:0] din_s2;
    } bls_regs_t;

    localparam bls_regs_t BLS_REGS_RST = '{
        st:     BLS_IDLE,
        addr:   32'h0,
        remain: 3'h0,
        total:  3'h0,
        dcnt:   3'h0,
        write:  1'b0,
        wbuf:   32'h0,
        rbuf:   32'h0,
        dout:   32'h0,
        rdata:  32'h0,
        done:   1'b0,
        ack_s1: BLS_ACK_NONE,
        ack_s2: BLS_ACK_NONE,
        din_s1: 32'h0,
        din_s2: 32'h0
    };

    bls_regs_t   r_r;
    bls_regs_t   r_nxt;
    logic [31:0] wlanes;
    logic [31:0] rshift;
    logic [2:0]  avail;
    logic [2:0]  moved;
    logic [1:0]  rlane;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Size code to byte count; code 00 means a full long word
    function automatic logic [2:0] size_bytes(input logic [1:0] code);
        size_bytes = (code == BLS_SIZE_LONG) ? BLS_LONG_BYTES
                                             : {1'b0, code};
    endfunction

    // Lanes the port can still take from the current offset
    function automatic logic [2:0] lane_avail(input logic [1:0] ack,
                                              input logic [1:0] off);
        case (ack)
            BLS_ACK_32: lane_avail = BLS_LONG_BYTES - {1'b0, off};
            BLS_ACK_16: lane_avail = BLS_WORD_BYTES - {2'h0, off[0]};
            default:    lane_avail = BLS_ONE_BYTE;
        endcase
    endfunction

    // First valid lane of the answering port
    function automatic logic [1:0] first_lane(input logic [1:0] ack,
                                              input logic [1:0] off);
        case (ack)
            BLS_ACK_32: first_lane = off;
            BLS_ACK_16: first_lane = {1'b0, off[0]};
            default:    first_lane = 2'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Lane multiplexer
    // ------------------------------------------------------------
    assign rlane = first_lane(r_r.ack_s2, r_r.addr[1:0]); // RQ4

    bls_lane_mux u_lane_mux (
        .i_wbytes (r_r.wbuf),
        .i_offset (r_r.addr[1:0]),
        .o_wlanes (wlanes),
        .i_rbus   (r_r.din_s2),
        .i_rlane  (rlane),
        .o_rshift (rshift)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus data is synchronised alongside the acknowledges, so both
    // reach the second stage on the same edge
    always_comb begin
        r_nxt        = r_r;
        r_nxt.done   = 1'b0;
        r_nxt.ack_s1 = {i_port_width_ack_hi_n, i_port_width_ack_lo_n};
        r_nxt.ack_s2 = r_r.ack_s1;
        r_nxt.din_s1 = i_data_in;
        r_nxt.din_s2 = r_r.din_s1;
        avail = lane_avail(r_r.ack_s2, r_r.addr[1:0]);  // RQ3
        moved = (r_r.remain < avail) ? r_r.remain : avail; // RQ5
        case (r_r.st)
            BLS_IDLE: begin
                if (i_req) begin
                    if (i_req_instr) begin
                        r_nxt.addr   = {i_req_addr[31:2],
                                        BLS_LONG_ALIGN}; // RQ14
                        r_nxt.remain = BLS_LONG_BYTES;   // RQ14
                        r_nxt.write  = 1'b0;
                    end else begin
                        r_nxt.addr   = i_req_addr;
                        r_nxt.remain = size_bytes(i_req_size);
                        r_nxt.write  = i_req_write;
                    end
                    r_nxt.total = r_nxt.remain;
                    // Left-justify the operand: next byte on top
                    r_nxt.wbuf  = i_req_wdata <<
                                  {(BLS_LONG_BYTES - r_nxt.remain),
                                   3'h0};
                    r_nxt.rbuf  = 32'h0;
                    r_nxt.dcnt  = 3'h0;
                    r_nxt.st    = BLS_ADDR;
                end
            end
            BLS_ADDR: begin
                r_nxt.dout = wlanes; // RQ6
                r_nxt.st   = BLS_DATA;
            end
            BLS_DATA: begin
                // Stays here until the port answers; no timeout
                if (r_r.ack_s2 != BLS_ACK_NONE) begin
                    for (int i = 0; i < 4; i++) begin
                        if (i < int'(moved)) begin
                            r_nxt.rbuf[8 * (3 - ((int'(r_r.dcnt) + i)
                                       % 4)) +: 8] =
                                rshift[8 * (3 - i) +: 8];
                        end
                    end
                    r_nxt.wbuf   = r_r.wbuf << {moved, 3'h0};
                    r_nxt.addr   = r_r.addr + {29'h0, moved}; // RQ2
                    r_nxt.remain = r_r.remain - moved;        // RQ5
                    r_nxt.dcnt   = r_r.dcnt + moved;
                    r_nxt.st     = BLS_REL;
                end
            end
            BLS_REL: begin
                // Wait for the port to drop its answer before reuse
                if (r_r.ack_s2 == BLS_ACK_NONE) begin
                    if (r_r.remain == 3'h0) begin
                        r_nxt.rdata = r_r.rbuf >>
                                      {(BLS_LONG_BYTES - r_r.total),
                                       3'h0};
                        r_nxt.done  = 1'b1;
                        r_nxt.st    = BLS_IDLE;
                    end else begin
                        r_nxt.st = BLS_ADDR; // RQ5
                    end
                end
            end
            default: begin
                r_nxt.st = BLS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            r_r <= BLS_REGS_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Strobes decode from Gray-coded state, so one bit changes except from REL to ADDR, where both do
    assign o_req_ready              = (r_r.st == BLS_IDLE);
    assign o_done                   = r_r.done;
    assign o_rdata                  = r_r.rdata;
    assign o_addr                   = r_r.addr;               // RQ2
    assign o_xfer_size_hi           = r_r.remain[1];          // RQ1
    assign o_xfer_size_lo           = r_r.remain[0];          // RQ1
    assign o_read_write             = ~r_r.write;
    assign o_address_valid_strobe_n = ~((r_r.st == BLS_ADDR) ||
                                        (r_r.st == BLS_DATA));
    assign o_data_phase_strobe_n    = ~(r_r.st == BLS_DATA);
    assign o_data_out               = r_r.dout;
    assign o_data_oe                = r_r.write &
                                      (r_r.st != BLS_IDLE);

endmodule

`default_nettype wire

// *** bench/bls_sizer_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

module bls_sizer_assertions
    import bls_pkg::*;
(
    // Clock, reset and request
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_req,
    input wire logic [1:0]  i_req_size,
    input wire logic [31:0] i_req_addr,
    input wire logic        i_req_write,
    input wire logic        i_req_instr,
    input wire logic        o_req_ready,
    input wire logic        o_done,
    // Processor bus
    input wire logic [31:0] o_addr,
    input wire logic        o_xfer_size_hi,
    input wire logic        o_xfer_size_lo,
    input wire logic        o_read_write,
    input wire logic        o_address_valid_strobe_n,
    input wire logic        o_data_phase_strobe_n,
    input wire logic        o_data_oe,
    input wire logic        i_port_width_ack_hi_n,
    input wire logic        i_port_width_ack_lo_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Request accepted on this edge
    logic take;
    assign take = i_req && o_req_ready;

    AST_INSTR_ALIGN: assert property (
        take && i_req_instr |=> o_addr[1:0] == 2'h0 && o_read_write
        && !o_xfer_size_hi && !o_xfer_size_lo)
        else $error("fetch cycle not long aligned");
    AST_SIZE_CODE: assert property (
        take && !i_req_instr |=>
        {o_xfer_size_hi, o_xfer_size_lo} == $past(i_req_size))
        else $error("first size code wrong");
    AST_FIRST_ADDR: assert property (
        take && !i_req_instr |=> o_addr == $past(i_req_addr))
        else $error("first address not the top byte");
    AST_WRITE_DIR: assert property (
        take && !i_req_instr && i_req_write |=> !o_read_write && o_data_oe)
        else $error("write cycle not driven");
    AST_DS_AFTER_AS: assert property (
        $fell(o_data_phase_strobe_n) |->
        $past(!o_address_valid_strobe_n) && !o_address_valid_strobe_n)
        else $error("data strobe without address strobe");
    AST_HOLD_CYCLE: assert property (
        !o_address_valid_strobe_n && $past(!o_address_valid_strobe_n) |->
        $stable(o_addr) && $stable({o_xfer_size_hi, o_xfer_size_lo}))
        else $error("address or size moved in a cycle");
    AST_ACK_END: assert property (
        !o_data_phase_strobe_n
        && !(i_port_width_ack_hi_n && i_port_width_ack_lo_n)
        |-> ##[1:4] o_data_phase_strobe_n)
        else $error("strobes not ended after answer");
    AST_DONE_IDLE: assert property (
        o_done |-> o_req_ready && o_address_valid_strobe_n)
        else $error("done while bus busy");

    // Main scenarios reached
    CV_FETCH: cover property (take && i_req_instr);
    CV_BYTE_PORT: cover property (!o_data_phase_strobe_n
        && i_port_width_ack_hi_n && !i_port_width_ack_lo_n);
    CV_DONE: cover property (o_done);
endmodule

bind bls_bus_sizer bls_sizer_assertions chk_u (.*);

`default_nettype wire

// *** bench/bls_port_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module bls_port_model
    import bls_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic [1:0]  i_width,
    input  wire logic [3:0]  i_wait,
    input  wire logic [31:0] i_addr,
    input  wire logic [1:0]  i_size,
    input  wire logic        i_rw,
    input  wire logic        i_ds_n,
    input  wire logic [31:0] i_data,
    output logic      [31:0] o_data,
    output logic             o_ack_hi_n = 1'b1,
    output logic             o_ack_lo_n = 1'b1
);
    logic [7:0]  mem [16];
    logic [31:0] junk = 32'h5a5a_a5a5;
    logic [3:0]  cnt = 4'h0;
    logic [3:0]  msk;
    logic [3:0]  base;
    logic [3:0]  sel_n;
    logic        bank_hit;
    int          nb;
    int          off;
    int          sz;

    // Lane geometry; narrow ports sit on the upper lanes
    always_comb begin
        nb = (i_width == BLS_ACK_32) ? 4 : (i_width == BLS_ACK_16) ? 2 : 1;
        msk = ~4'(nb - 1);
        base = i_addr[3:0] & msk;
        off = int'(i_addr[1:0] & ~msk[1:0]);
        sz = (i_size == 2'h0) ? 4 : int'(i_size);
        // The modelled bank spans the low sixteen bytes only
        bank_hit = (i_addr[31:4] == 28'h0);
        // Active-low lane selects, rebuilt from scratch each cycle
        for (int l = 0; l < 4; l++)
            sel_n[l] = !(bank_hit && l < nb &&
                (i_rw || (l >= off && l < off + sz)));
        // Undriven lanes change every cycle so stale data never passes
        o_data = junk;
        if (i_rw && !(o_ack_hi_n && o_ack_lo_n))
            for (int l = 0; l < 4; l++)
                if (!sel_n[l])
                    o_data[31-8*l -: 8] = mem[4'(base + l)];
    end

    // Answer after a programmable wait, hold until strobe ends
    always @(posedge i_clk) begin
        junk <= {junk[30:0], ~junk[31]};
        if (i_ds_n) begin
            cnt <= 4'h0;
            {o_ack_hi_n, o_ack_lo_n} <= BLS_ACK_NONE;
        end else if (cnt < i_wait) begin
            cnt <= cnt + 4'h1;
        end else begin
            {o_ack_hi_n, o_ack_lo_n} <= i_width;
            // Only lanes that carry operand bytes are written
            for (int l = 0; l < 4; l++)
                if (!i_rw && !sel_n[l])
                    mem[4'(base + l)] <= i_data[31-8*l -: 8];
        end
    end
endmodule

`default_nettype wire

// *** bench/bls_bus_sizer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module bls_bus_sizer_tb;
    import bls_pkg::*;

    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_req = 1'b0;
    logic        i_req_write = 1'b0;
    logic        i_req_instr = 1'b0;
    logic [1:0]  i_req_size = 2'h0;
    logic [31:0] i_req_addr = 32'h0;
    logic [31:0] i_req_wdata = 32'h0;
    logic [1:0]  width = BLS_ACK_32;
    logic [3:0]  wait_n = 4'h0;
    logic [31:0] i_data_in, o_rdata, o_addr, dout;
    logic        o_req_ready, o_done, rw, as_n, ds_n, oe, ds_q = 1'b1;
    logic        ack_hi_n, ack_lo_n, sz_hi, sz_lo;
    logic [36:0] log_q[$];
    int          fail_count = 0;
    int          n_compared = 0;

    initial forever #12.5 i_clk = ~i_clk;

    bls_bus_sizer dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req),
        .i_req_size(i_req_size), .i_req_addr(i_req_addr),
        .i_req_write(i_req_write), .i_req_instr(i_req_instr),
        .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready),
        .o_done(o_done), .o_rdata(o_rdata), .o_addr(o_addr),
        .o_xfer_size_hi(sz_hi), .o_xfer_size_lo(sz_lo), .o_read_write(rw),
        .o_address_valid_strobe_n(as_n), .o_data_phase_strobe_n(ds_n),
        .o_data_out(dout), .o_data_oe(oe), .i_data_in(i_data_in),
        .i_port_width_ack_hi_n(ack_hi_n), .i_port_width_ack_lo_n(ack_lo_n));

    bls_port_model mem_u (.i_clk(i_clk), .i_width(width), .i_wait(wait_n),
        .i_addr(o_addr), .i_size({sz_hi, sz_lo}), .i_rw(rw), .i_ds_n(ds_n),
        .i_data(dout), .o_data(i_data_in), .o_ack_hi_n(ack_hi_n),
        .o_ack_lo_n(ack_lo_n));

    // Log each bus cycle as its data strobe starts
    // Previous strobe level is compared before it is updated
    always @(negedge i_clk) begin
        if (ds_n === 1'b0 && ds_q === 1'b1)
            log_q.push_back({sz_hi, sz_lo, o_addr[1:0], rw, dout});
        ds_q = ds_n;
    end

    task automatic check(input logic [36:0] got, input logic [36:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One operand request, waiting boundedly for ready and done
    task automatic xfer(input logic [1:0] sz, input logic [31:0] a,
                        input logic [31:0] d, input logic w, ins);
        int t;
        for (t = 0; t < 50 && o_req_ready !== 1'b1; t++) @(negedge i_clk);
        if (t == 50) begin
            fail_count++;
            print_verdict();
        end
        i_req_size = sz;
        i_req_addr = a;
        i_req_wdata = d;
        i_req_write = w;
        i_req_instr = ins;
        i_req = 1'b1;
        @(negedge i_clk);
        i_req = 1'b0;
        for (t = 0; t < 300 && o_done !== 1'b1; t++) @(negedge i_clk);
        if (t == 300) begin
            fail_count++;
            print_verdict();
        end
    endtask

    // Every size code at every offset on every port width
    task automatic t_sizes;
        logic [31:0] d, m;
        int n;
        d = 32'h8c4a_2d17;
        for (int w = 0; w < 3; w++)
            for (int s = 0; s < 4; s++)
                for (int a = 0; a < 4; a++) begin
                    width = w[1:0];
                    wait_n = 4'(w);
                    n = (s == 0) ? 4 : s;
                    for (int i = 0; i < 16; i++) mem_u.mem[i] = 8'h00;
                    xfer(s[1:0], 32'(4 + a), d, 1'b1, 1'b0);
                    for (int k = 0; k < n; k++)
                        check(mem_u.mem[4+a+k], d[8*(n-1-k) +: 8]);
                    m = (n == 4) ? 32'hffff_ffff : (32'h1 << 8 * n) - 1;
                    xfer(s[1:0], 32'(4 + a), 32'h0, 1'b0, 1'b0);
                    check(o_rdata & m, d & m);
                end
        $display("test sizes done");
    endtask

    // Odd long write to a word port splits into three cycles
    task automatic t_split;
        width = BLS_ACK_16;
        wait_n = 4'h0;
        log_q.delete();
        xfer(2'h0, 32'h1, 32'ha1b2_c3d4, 1'b1, 1'b0);
        check(log_q.size(), 3);
        check({log_q[0][36:32], log_q[0][23:16]}, {5'h02, 8'ha1});
        check({log_q[1][36:32], log_q[1][31:16]}, {5'h1c, 16'hb2c3});
        check({log_q[2][36:32], log_q[2][31:24]}, {5'h08, 8'hd4});
        $display("test split done");
    endtask

    // Fetch from an unaligned address (0x6) is made long aligned
    task automatic t_instr;
        width = BLS_ACK_32;
        for (int i = 0; i < 16; i++) mem_u.mem[i] = 8'(8'h30 + i);
        log_q.delete();
        xfer(2'h1, 32'h6, 32'h0, 1'b1, 1'b1);
        check(log_q[0][36:32], 5'h01);
        check(o_rdata, 32'h3435_3637);
        $display("test fetch done");
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        t_sizes();
        t_split();
        t_instr();
        print_verdict();
    end
endmodule

`default_nettype wire
